// ---- nfc_pkg.sv ----
// nand host controller package: offsets, commands, timings and types
package nfc_pkg;
	// clock and pin timing
	localparam int CLK_NS = 8;
	localparam int T_PULSE_NS = 16;
	localparam int T_REA_NS = 20;
	localparam int T_WHR_NS = 80;
	localparam int T_WB_NS = 100;
	localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int REA_CYC = (T_REA_NS + CLK_NS - 1) / CLK_NS;
	localparam int WHR_CYC = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
	localparam int WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
	localparam int SYNC_LAT = 2;
	localparam int READ_LOW_CYC = REA_CYC + SYNC_LAT;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_COL = 8'h04;
	localparam logic [7:0] OFF_ROW = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0C;
	localparam logic [7:0] OFF_DATA = 8'h10;
	localparam logic [3:0] BE_FULL = 4'hF;
	// status word bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_RB = 1;
	localparam int ST_ERR = 2;
	localparam int ST_FAIL = 3;
	localparam int ST_CACHE = 4;
	localparam int ST_PROG = 5;
	localparam int ST_DOUT = 6;
	localparam int ST_SMODE = 7;
	localparam int ST_BYTE = 8;
	localparam int DEV_FAIL_BIT = 0;
	// array geometry
	localparam logic [5:0] LAST_PAGE = 6'h3F;
	localparam logic [5:0] PAGE_ONE = 6'h01;
	localparam int BLK_LO = 6;
	localparam int BLK_HI = 16;
	localparam logic [2:0] MAX_PARTIAL = 3'h4;
	// device command bytes
	localparam logic [7:0] CMD_READ1 = 8'h00;
	localparam logic [7:0] CMD_READ2 = 8'h30;
	localparam logic [7:0] CMD_CACHE = 8'h31;
	localparam logic [7:0] CMD_CEND = 8'h3F;
	localparam logic [7:0] CMD_ROUT1 = 8'h05;
	localparam logic [7:0] CMD_ROUT2 = 8'hE0;
	localparam logic [7:0] CMD_PROG1 = 8'h80;
	localparam logic [7:0] CMD_PROG2 = 8'h10;
	localparam logic [7:0] CMD_RIN = 8'h85;
	localparam logic [7:0] CMD_STATUS = 8'h70;

	typedef enum logic [3:0] {
		OP_READ = 4'h1, OP_CSEQ = 4'h2, OP_CRND = 4'h3, OP_CEND = 4'h4,
		OP_ROUT = 4'h5, OP_PROG = 4'h6, OP_CONF = 4'h7, OP_RIN = 4'h8,
		OP_STATUS = 4'h9, OP_RMODE = 4'hA
	} nfc_op_t;
	typedef enum logic [1:0] {
		K_CMD = 2'h0, K_ADDR = 2'h1, K_DIN = 2'h2, K_DOUT = 2'h3
	} nfc_kind_t;
	typedef enum logic [1:0] {
		W_NONE = 2'h0, W_RB = 2'h1, W_WHR = 2'h2, W_STAT = 2'h3
	} nfc_wait_t;
	typedef struct packed {
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
		logic io_oe;
		logic [7:0] io_out;
	} nfc_pins_t;
	typedef struct packed {
		logic [7:0] cmd1;
		logic [2:0] naddr;
		logic has2;
		logic [7:0] cmd2;
		nfc_wait_t wt;
	} nfc_desc_t;

	localparam nfc_pins_t PINS_IDLE = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0,
		8'h00};

	// command, address count and wait kind of each operation
	function automatic nfc_desc_t nfc_decode(input nfc_op_t op);
		nfc_desc_t d;
		d = '{CMD_READ1, 3'h0, 1'b0, CMD_READ1, W_NONE};
		case (op)
			OP_READ: d = '{CMD_READ1, 3'h5, 1'b1, CMD_READ2, W_RB};
			OP_CSEQ: d = '{CMD_CACHE, 3'h0, 1'b0, CMD_CACHE, W_RB};
			OP_CRND: d = '{CMD_READ1, 3'h5, 1'b1, CMD_CACHE, W_RB};
			OP_CEND: d = '{CMD_CEND, 3'h0, 1'b0, CMD_CEND, W_RB};
			OP_ROUT: d = '{CMD_ROUT1, 3'h2, 1'b1, CMD_ROUT2, W_WHR};
			OP_PROG: d = '{CMD_PROG1, 3'h5, 1'b0, CMD_PROG1, W_WHR};
			OP_CONF: d = '{CMD_PROG2, 3'h0, 1'b0, CMD_PROG2, W_RB};
			OP_RIN: d = '{CMD_RIN, 3'h2, 1'b0, CMD_RIN, W_WHR};
			OP_STATUS: d = '{CMD_STATUS, 3'h0, 1'b0, CMD_STATUS, W_STAT};
			default: d = '{CMD_READ1, 3'h0, 1'b0, CMD_READ1, W_NONE};
		endcase
		return d;
	endfunction : nfc_decode
endpackage : nfc_pkg

// ---- nfc_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns

module nfc_sync #(
	parameter int W = 9
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// asynchronous in, synchronous out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	////////////////////////////////////////////////////////////////////////
	// one chain per bit; the first stage feeds only the second
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic s1_reg;
		logic s2_reg;
		always_ff @(posedge clock) begin
			if (!rst_n) begin
				s1_reg <= 1'b0;
				s2_reg <= 1'b0;
			end else begin
				s1_reg <= d[i];
				s2_reg <= s1_reg;
			end
		end
		assign q[i] = s2_reg;
	end

endmodule : nfc_sync

// ---- nfc_cycle.sv ----
// single bus cycle engine: command, address, data in or data out
`timescale 1ns/1ns

module nfc_cycle import nfc_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// request
	input wire logic start,
	input wire nfc_kind_t kind,
	input wire logic [7:0] wbyte,
	input wire logic [7:0] io_sync,
	// answer
	output logic done,
	output logic [7:0] rbyte,
	// pins
	output nfc_pins_t pins
);

	typedef enum logic [1:0] {
		E_IDLE = 2'h0, E_SETUP = 2'h1, E_LOW = 2'h2, E_HIGH = 2'h3
	} nfc_eng_t;

	nfc_eng_t st_reg, st_next;
	nfc_kind_t kind_reg, kind_next;
	nfc_pins_t pins_reg, pins_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] rbyte_reg, rbyte_next;
	logic done_reg, done_next;
	logic [3:0] low_len;

	////////////////////////////////////////////////////////////////////////
	// read strobe is held longer to cover access time plus sync latency
	assign low_len = (kind_reg == K_DOUT) ? 4'(READ_LOW_CYC) : 4'(PULSE_CYC);

	// next state: setup one cycle, strobe low, then hold with lines kept
	always_comb begin
		st_next = st_reg;
		kind_next = kind_reg;
		pins_next = pins_reg;
		cnt_next = cnt_reg;
		rbyte_next = rbyte_reg;
		done_next = 1'b0;
		case (st_reg)
			E_IDLE: begin
				if (start) begin
					kind_next = kind;
					pins_next.ce_n = 1'b0;
					pins_next.cle = (kind == K_CMD);
					pins_next.ale = (kind == K_ADDR);
					pins_next.io_oe = (kind != K_DOUT);
					pins_next.io_out = wbyte;
					st_next = E_SETUP;
				end
			end
			E_SETUP: begin
				pins_next.we_n = (kind_reg == K_DOUT);
				pins_next.re_n = (kind_reg != K_DOUT);
				cnt_next = 4'h0;
				st_next = E_LOW;
			end
			E_LOW: begin
				cnt_next = cnt_reg + 4'h1;
				if (cnt_reg == low_len - 4'h1) begin
					pins_next.we_n = 1'b1;
					pins_next.re_n = 1'b1;
					if (kind_reg == K_DOUT) begin
						rbyte_next = io_sync;
					end
					cnt_next = 4'h0;
					st_next = E_HIGH;
				end
			end
			E_HIGH: begin
				cnt_next = cnt_reg + 4'h1;
				if (cnt_reg == 4'(PULSE_CYC - 1)) begin
					pins_next = PINS_IDLE;
					done_next = 1'b1;
					st_next = E_IDLE;
				end
			end
			default: st_next = E_IDLE;
		endcase
	end

	// registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_reg <= E_IDLE;
			kind_reg <= K_CMD;
			pins_reg <= PINS_IDLE;
			cnt_reg <= 4'h0;
			rbyte_reg <= 8'h00;
			done_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			kind_reg <= kind_next;
			pins_reg <= pins_next;
			cnt_reg <= cnt_next;
			rbyte_reg <= rbyte_next;
			done_reg <= done_next;
		end
	end

	assign pins = pins_reg;
	assign rbyte = rbyte_reg;
	assign done = done_reg;

endmodule : nfc_cycle

// ---- nfc_host.sv ----
// nand host controller: avalon-mm registers and command sequencer
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ns

// Operation
// [R1] cache read start only after a completed plain page read
// [R2] device loads next page into data buffer during cache output
// [R3] device takes cache commands when ready or during cache read
// [R4] after cache start or random, device is busy then ready again
// [R5] sequential cache read never steps past the block's last page
// [R6] without a new address the next sequential page is fetched
// [R7] random cache read: 00h, five address cycles, 31h; row used
// [R8] cache end copies data buffer to cache buffer, then fully ready
// [R9] after a cached command, output starts at column zero
// [R10] random column output: 05h, two column cycles, E0h
// [R11] wait a minimum gap after E0h before reading data
// [R12] pages in a block are programmed in ascending order
// [R13] at most four partial programs of one page between erases
// [R14] a partial program may be any consecutive run of bytes
// [R15] program: 80h, five address cycles, data, 10h, then busy
// [R16] device takes 80h-10h during a cached program too
// [R17] random data input may relocate column before confirm
// [R18] completion is tracked by the ready/busy pin or status read
// [R19] after a program, read status and check the fail bit
// [R20] device verify flags only zeros that stayed one
// [R21] device programs, verifies and retries after the 10h edge
// [R22] page read: 00h, five address cycles, 30h, then busy
// [R23] after status polling, 00h alone re-enables data output
// [R24] device ignores commands its ready state does not allow
// [R25] ready/busy pin low exactly when the ready bit is zero
module nfc_host import nfc_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// avalon-mm slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// nand pins
	output nfc_pins_t pins,
	input wire logic [7:0] io_in,
	input wire logic rb_n_in
);

	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_C1 = 4'h1, S_AD = 4'h2, S_C2 = 4'h3,
		S_WB = 4'h4, S_WRB = 4'h5, S_WHR = 4'h6, S_SC = 4'h7,
		S_SR = 4'h8, S_DIO = 4'h9
	} nfc_state_t;

	nfc_state_t state_reg, state_next;
	nfc_op_t op_reg, op_next;
	logic [2:0] idx_reg, idx_next;
	logic [4:0] cnt_reg, cnt_next;
	logic pend_reg, pend_next;
	logic ack_reg, ack_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [15:0] col_reg, col_next;
	logic [23:0] row_reg, row_next;
	logic [23:0] cur_reg, cur_next;
	logic [7:0] stat_reg, stat_next;
	logic err_reg, err_next;
	logic fail_reg, fail_next;
	logic ropen_reg, ropen_next;
	logic cache_reg, cache_next;
	logic popen_reg, popen_next;
	logic dout_reg, dout_next;
	logic smode_reg, smode_next;
	logic pvalid_reg, pvalid_next;
	logic [10:0] pblk_reg, pblk_next;
	logic [5:0] ppage_reg, ppage_next;
	logic [2:0] pcnt_reg, pcnt_next;

	logic rb_s;
	logic [7:0] io_s;
	logic eng_start, eng_done, issuing, acc, sel_data, data_ok, ctrl_wr;
	logic same_blk;
	nfc_kind_t eng_kind;
	logic [7:0] eng_byte, eng_rbyte;
	nfc_desc_t desc;
	nfc_op_t ctrl_op;
	logic [31:0] stat_word;

	// wait that follows the last command or address cycle of an operation
	function automatic nfc_state_t after_cmd(input nfc_wait_t wt);
		case (wt)
			W_RB: return S_WB;
			W_WHR: return S_WHR;
			W_STAT: return S_SR;
			default: return S_IDLE;
		endcase
	endfunction : after_cmd

	////////////////////////////////////////////////////////////////////////
	// pin inputs pass two flops before any use
	nfc_sync #(.W(9)) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.d({rb_n_in, io_in}),
		.q({rb_s, io_s})
	);

	nfc_cycle u_cycle (
		.clock(clock),
		.rst_n(rst_n),
		.start(eng_start),
		.kind(eng_kind),
		.wbyte(eng_byte),
		.io_sync(io_s),
		.done(eng_done),
		.rbyte(eng_rbyte),
		.pins(pins)
	);

	////////////////////////////////////////////////////////////////////////
	// bus decode; a control write takes effect at its acknowledge edge
	assign acc = read | write;
	assign sel_data = (address == OFF_DATA);
	assign data_ok = write ? popen_reg : (dout_reg | smode_reg);
	assign ctrl_wr = ack_reg & write & (address == OFF_CTRL) &
		(byteenable == BE_FULL);
	assign ctrl_op = nfc_op_t'(writedata[3:0]);
	assign desc = nfc_decode(op_reg);
	assign same_blk = pvalid_reg & (row_reg[BLK_HI:BLK_LO] == pblk_reg);
	assign stat_word = {16'h0000, stat_reg, smode_reg, dout_reg,
		popen_reg, cache_reg, fail_reg, err_reg, rb_s,
		state_reg != S_IDLE};
	assign issuing = (state_reg == S_C1) | (state_reg == S_AD) |
		(state_reg == S_C2) | (state_reg == S_SC) |
		(state_reg == S_SR) | (state_reg == S_DIO);
	// one request per pin cycle; pend blocks a restart until done
	assign eng_start = issuing & ~pend_reg;

	// byte and kind of the pin cycle for the current step
	always_comb begin
		eng_kind = K_CMD;
		eng_byte = desc.cmd1;
		case (state_reg)
			S_AD: begin
				eng_kind = K_ADDR;
				case (idx_reg)
					3'h0: eng_byte = col_reg[7:0];
					3'h1: eng_byte = col_reg[15:8];
					3'h2: eng_byte = row_reg[7:0];
					3'h3: eng_byte = row_reg[15:8];
					default: eng_byte = row_reg[23:16];
				endcase
			end
			S_C2: eng_byte = desc.cmd2;
			S_SC: eng_byte = CMD_STATUS;
			S_SR: begin
				eng_kind = K_DOUT;
				eng_byte = 8'h00;
			end
			S_DIO: begin
				eng_kind = write ? K_DIN : K_DOUT;
				eng_byte = writedata[7:0];
			end
			default: eng_byte = desc.cmd1;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next values of the whole controller
	always_comb begin
		logic ok;
		ok = 1'b1;
		state_next = state_reg;
		op_next = op_reg;
		idx_next = idx_reg;
		cnt_next = cnt_reg;
		pend_next = pend_reg;
		ack_next = 1'b0;
		rdata_next = rdata_reg;
		col_next = col_reg;
		row_next = row_reg;
		cur_next = cur_reg;
		stat_next = stat_reg;
		err_next = err_reg;
		fail_next = fail_reg;
		ropen_next = ropen_reg;
		cache_next = cache_reg;
		popen_next = popen_reg;
		dout_next = dout_reg;
		smode_next = smode_reg;
		pvalid_next = pvalid_reg;
		pblk_next = pblk_reg;
		ppage_next = ppage_reg;
		pcnt_next = pcnt_reg;
		if (eng_start) begin
			pend_next = 1'b1;
		end else if (eng_done) begin
			pend_next = 1'b0;
		end
		// bus answers; data port stalls until its pin cycle ends
		if (acc && !ack_reg) begin
			if (!sel_data) begin
				ack_next = 1'b1;
				case (address)
					OFF_CTRL: rdata_next = {28'h0000000, op_reg};
					OFF_COL: rdata_next = {16'h0000, col_reg};
					OFF_ROW: rdata_next = {8'h00, row_reg};
					OFF_STAT: rdata_next = stat_word;
					default: rdata_next = 32'h00000000;
				endcase
			end else if (state_reg == S_IDLE && !data_ok) begin
				ack_next = 1'b1;
				rdata_next = 32'h00000000;
				err_next = 1'b1;
			end else if (state_reg == S_IDLE) begin
				state_next = S_DIO;
			end else if (state_reg == S_DIO && eng_done) begin
				ack_next = 1'b1;
				rdata_next = {24'h000000, eng_rbyte};
				state_next = S_IDLE;
			end
		end
		if (ack_reg && write && byteenable == BE_FULL) begin
			if (address == OFF_COL) col_next = writedata[15:0];
			if (address == OFF_ROW) row_next = writedata[23:0];
		end
		// operation start with host-side legality checks
		if (ctrl_wr) begin
			if (state_reg != S_IDLE) ok = 1'b0;
			case (ctrl_op)
				// [R1] [R5] prior read, stay in block
				OP_CSEQ: ok = ok & ropen_reg & (cur_reg[5:0] != LAST_PAGE);
				// [R5] random page within the same block
				OP_CRND: ok = ok & ropen_reg &
					(row_reg[BLK_HI:BLK_LO] == cur_reg[BLK_HI:BLK_LO]);
				OP_CEND: ok = ok & ropen_reg;
				OP_ROUT: ok = ok & (dout_reg | cache_reg);
				// [R12] [R13] ascending pages, partial cap
				OP_PROG: ok = ok & ~(same_blk & (row_reg[5:0] < ppage_reg)) &
					~(same_blk & (row_reg[5:0] == ppage_reg) &
					(pcnt_reg == MAX_PARTIAL));
				// [R17] relocation only inside data input
				OP_CONF, OP_RIN: ok = ok & popen_reg;
				OP_READ, OP_STATUS, OP_RMODE: ok = ok;
				default: ok = 1'b0;
			endcase
			err_next = ~ok;
			if (ok) begin
				op_next = ctrl_op;
				idx_next = 3'h0;
				state_next = S_C1;
				case (ctrl_op)
					OP_READ: begin
						ropen_next = 1'b1;
						cache_next = 1'b0;
						popen_next = 1'b0;
						dout_next = 1'b0;
						smode_next = 1'b0;
						cur_next = row_reg;
					end
					// [R6] host tracks the next sequential page
					OP_CSEQ: begin
						cache_next = 1'b1;
						dout_next = 1'b0;
						cur_next = {cur_reg[23:6], cur_reg[5:0] + PAGE_ONE};
					end
					OP_CRND: begin
						cache_next = 1'b1;
						dout_next = 1'b0;
						cur_next = row_reg;
					end
					OP_CEND: begin
						cache_next = 1'b0;
						ropen_next = 1'b0;
						dout_next = 1'b0;
					end
					OP_PROG: begin
						popen_next = 1'b1;
						ropen_next = 1'b0;
						dout_next = 1'b0;
						smode_next = 1'b0;
						pvalid_next = 1'b1;
						pblk_next = row_reg[BLK_HI:BLK_LO];
						ppage_next = row_reg[5:0];
						pcnt_next = (same_blk && row_reg[5:0] == ppage_reg) ?
							pcnt_reg + 3'h1 : 3'h1;
					end
					OP_CONF: popen_next = 1'b0;
					OP_STATUS: begin
						smode_next = 1'b1;
						dout_next = 1'b0;
					end
					// [R23] plain 00h returns to data output
					OP_RMODE: begin
						smode_next = 1'b0;
						dout_next = 1'b1;
					end
					default: dout_next = dout_reg;
				endcase
			end
		end
		// command sequencing
		case (state_reg)
			S_C1: begin
				if (eng_done) begin
					cnt_next = 5'h00;
					idx_next = 3'h0;
					if (desc.naddr != 3'h0) begin
						state_next = S_AD;
					end else begin
						state_next = after_cmd(desc.wt);
					end
				end
			end
			// [R7] [R10] [R15] [R22] address cycles by op
			S_AD: begin
				if (eng_done) begin
					idx_next = idx_reg + 3'h1;
					cnt_next = 5'h00;
					if (idx_reg == desc.naddr - 3'h1) begin
						state_next = desc.has2 ? S_C2 : after_cmd(desc.wt);
					end
				end
			end
			S_C2: begin
				if (eng_done) begin
					cnt_next = 5'h00;
					state_next = after_cmd(desc.wt);
				end
			end
			// ready/busy falls only some time after the last write edge
			S_WB: begin
				cnt_next = cnt_reg + 5'h01;
				if (cnt_reg == 5'(WB_CYC - 1)) state_next = S_WRB;
			end
			// [R18] [R4] [R8] [R21] wait for ready pin
			S_WRB: begin
				if (rb_s) begin
					if (op_reg == OP_CONF) begin
						state_next = S_SC;
					end else begin
						// [R9] output enabled; the device starts it at column zero after cache commands
						dout_next = 1'b1;
						state_next = S_IDLE;
					end
				end
			end
			// [R11] gap before data after the last cycle
			S_WHR: begin
				cnt_next = cnt_reg + 5'h01;
				if (cnt_reg == 5'(WHR_CYC - 1)) state_next = S_IDLE;
			end
			// [R19] status read closes every program
			S_SC: begin
				if (eng_done) state_next = S_SR;
			end
			S_SR: begin
				if (eng_done) begin
					stat_next = eng_rbyte;
					smode_next = 1'b1;
					if (op_reg == OP_CONF) begin
						fail_next = eng_rbyte[DEV_FAIL_BIT];
					end
					state_next = S_IDLE;
				end
			end
			default: cnt_next = cnt_reg;
		endcase
	end

	// registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
			op_reg <= OP_READ;
			idx_reg <= 3'h0;
			cnt_reg <= 5'h00;
			pend_reg <= 1'b0;
			ack_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			col_reg <= 16'h0000;
			row_reg <= 24'h000000;
			cur_reg <= 24'h000000;
			stat_reg <= 8'h00;
			err_reg <= 1'b0;
			fail_reg <= 1'b0;
			ropen_reg <= 1'b0;
			cache_reg <= 1'b0;
			popen_reg <= 1'b0;
			dout_reg <= 1'b0;
			smode_reg <= 1'b0;
			pvalid_reg <= 1'b0;
			pblk_reg <= 11'h000;
			ppage_reg <= 6'h00;
			pcnt_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			op_reg <= op_next;
			idx_reg <= idx_next;
			cnt_reg <= cnt_next;
			pend_reg <= pend_next;
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			col_reg <= col_next;
			row_reg <= row_next;
			cur_reg <= cur_next;
			stat_reg <= stat_next;
			err_reg <= err_next;
			fail_reg <= fail_next;
			ropen_reg <= ropen_next;
			cache_reg <= cache_next;
			popen_reg <= popen_next;
			dout_reg <= dout_next;
			smode_reg <= smode_next;
			pvalid_reg <= pvalid_next;
			pblk_reg <= pblk_next;
			ppage_reg <= ppage_next;
			pcnt_reg <= pcnt_next;
		end
	end

	assign readdata = rdata_reg;
	assign waitrequest = ~ack_reg;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_e0_sent;
		state_reg == S_C2 && eng_done && op_reg == OP_ROUT;
	endsequence
	sequence s_read_sent;
		state_reg == S_C2 && eng_done && op_reg == OP_READ;
	endsequence

	a_cache_order: assert property ( // [R1]
		ctrl_wr && ctrl_op == OP_CSEQ && !ropen_reg |=>
		err_reg && state_reg == S_IDLE)
		else $error("cache start accepted without page read");
	a_block_edge: assert property ( // [R5]
		ctrl_wr && ctrl_op == OP_CSEQ && cur_reg[5:0] == LAST_PAGE |=>
		err_reg && state_reg == S_IDLE)
		else $error("cache start crossed block end");
	a_page_order: assert property ( // [R12]
		ctrl_wr && ctrl_op == OP_PROG && same_blk &&
		row_reg[5:0] < ppage_reg |=> err_reg && state_reg == S_IDLE)
		else $error("program to lower page accepted");
	a_partial_cap: assert property ( // [R13]
		ctrl_wr && ctrl_op == OP_PROG && same_blk &&
		row_reg[5:0] == ppage_reg && pcnt_reg == MAX_PARTIAL |=> err_reg)
		else $error("fifth partial program accepted");
	a_rand_five: assert property ( // [R7]
		state_reg == S_C2 && op_reg == OP_CRND && $past(state_reg) == S_AD
		|-> $past(idx_reg) == 3'h4)
		else $error("random cache read without five address cycles");
	a_col_two: assert property ( // [R10]
		state_reg == S_C2 && op_reg == OP_ROUT && $past(state_reg) == S_AD
		|-> $past(idx_reg) == 3'h1)
		else $error("random output without two column cycles");
	a_whr_gap: assert property ( // [R11]
		s_e0_sent |=> (state_reg == S_WHR)[*8] ##1 (state_reg == S_WHR)[*2])
		else $error("data gap after E0h too short");
	a_read_busy: assert property ( // [R22]
		s_read_sent |=> (state_reg == S_WB)[*8] ##[1:10] state_reg == S_WRB)
		else $error("page read did not wait for busy");
	a_busy_hold: assert property ( // [R18]
		state_reg == S_WRB && !rb_s |=> state_reg == S_WRB)
		else $error("left busy wait while pin low");
	a_prog_status: assert property ( // [R19]
		state_reg == S_WRB && rb_s && op_reg == OP_CONF |=>
		state_reg == S_SC ##[1:20] state_reg == S_SR)
		else $error("no status read after program");
	a_read_mode: assert property ( // [R23]
		ctrl_wr && ctrl_op == OP_RMODE && state_reg == S_IDLE |=>
		state_reg == S_C1 && dout_reg && !smode_reg ##[1:20]
		state_reg == S_IDLE)
		else $error("read mode did not return to data output");

endmodule : nfc_host

// ---- nfc_dev.sv ----
// behavioural nand device facing the host controller pins
`timescale 1ns/1ns
module nfc_dev import nfc_pkg::*; (
	// pins from host
	input wire nfc_pins_t pins,
	// device outputs
	output logic [7:0] io_in,
	output logic rb_n_in
);
	logic [7:0] cmd, col, row, cb, db;
	logic stat, anew;
	int na;
	initial begin
		io_in = 8'h5A;
		rb_n_in = 1'b1;
		{cmd, col, row, cb, db, stat, anew} = '0;
		na = 0;
	end
	task automatic busy();
		rb_n_in <= #40 1'b0;
		rb_n_in <= #300 1'b1;
	endtask : busy
	// of the commands only status is taken while busy; address cycles are taken always
	always @(posedge pins.we_n) begin
		if (!pins.ce_n && pins.cle &&
			(rb_n_in || pins.io_out == CMD_STATUS)) begin
			cmd = pins.io_out;
			na = 0;
			stat = (cmd == CMD_STATUS);
			if (cmd == CMD_READ2) begin
				cb = row;
				db = row;
				anew = 1'b0;
			end
			// cache loads restart at column zero
			if (cmd == CMD_CACHE || cmd == CMD_CEND) begin
				cb = db;
				db = anew ? row : db + 8'h01;
				col = 8'h00;
				anew = 1'b0;
			end
			// page read, cache loads and program confirm run behind busy
			if (cmd inside {CMD_READ2, CMD_CACHE, CMD_CEND, CMD_PROG2}) busy();
		end else if (!pins.ce_n && pins.ale) begin
			if (na == 0) col = pins.io_out;
			if (na == 2) row = pins.io_out;
			na++;
			anew = (na > 2);
		end
	end
	// status byte or cache byte, fail bit clear
	always @(negedge pins.re_n) begin
		io_in <= #10 stat ? {1'b1, rb_n_in, rb_n_in, 5'h00} : col ^ cb;
		if (!stat) col = col + 8'h01;
	end
	// released bus shows the inverse, so a stale byte never matches
	always @(posedge pins.re_n) io_in <= #5 ~io_in;
endmodule : nfc_dev

// ---- tb_top.sv ----
// self-checking bench for the nand host controller
`timescale 1ns/1ns
module tb_top import nfc_pkg::*;;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [3:0] byteenable = BE_FULL;
	logic [31:0] writedata = 32'h0, readdata, rd;
	logic waitrequest, rb_n_in;
	logic [7:0] io_in, pg, rr, c;
	nfc_pins_t pins;
	int err_count = 0;
	int n_tests = 0;
	int cyc = 0;
	always #4 clock = ~clock;
	nfc_host nfc_host_i (.clock(clock), .rst_n(rst_n), .address(address),
		.read(read), .write(write), .byteenable(byteenable),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .pins(pins), .io_in(io_in),
		.rb_n_in(rb_n_in));
	nfc_dev nfc_dev_i (.pins(pins), .io_in(io_in), .rb_n_in(rb_n_in));
	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input string s, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask : chk
	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		address <= a;
		write <= w;
		read <= ~w;
		writedata <= d;
		do @(posedge clock);
		while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
	endtask : bus
	task automatic op(input nfc_op_t o);
		bus(OFF_CTRL, 1'b1, {28'h0, o});
		do bus(OFF_STAT, 1'b0, 32'h0);
		while (rd[ST_BUSY] !== 1'b0);
	endtask : op
	task automatic rdn(input logic [7:0] p, c0, input int k);
		for (int i = 0; i < k; i++) begin
			bus(OFF_DATA, 1'b0, 32'h0);
			chk("byte", {24'h0, (c0 + 8'(i)) ^ p}, rd);
		end
	endtask : rdn
	// hang guard
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(32'hAD73));
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		bus(8'h20, 1'b0, 32'h0);
		chk("unmapped", 32'h0, rd);
		pg = 8'($urandom_range(60, 1));
		c = 8'($urandom_range(200));
		bus(OFF_COL, 1'b1, {24'h0, c});
		bus(OFF_ROW, 1'b1, {24'h0, pg});
		op(OP_READ);
		rdn(pg, c, 3); // plain page read
		c = 8'($urandom_range(250));
		bus(OFF_COL, 1'b1, {24'h0, c});
		op(OP_ROUT);
		rdn(pg, c, 2); // random column
		$display("test read done");
		op(OP_CSEQ);
		rdn(pg, 8'h00, 2); // first cache load
		op(OP_CSEQ);
		rdn(pg + 8'h01, 8'h00, 2); // next page
		rr = 8'($urandom_range(63));
		bus(OFF_COL, 1'b1, 32'h33);
		bus(OFF_ROW, 1'b1, {24'h0, rr});
		op(OP_CRND);
		rdn(pg + 8'h02, 8'h00, 2); // cache random
		op(OP_CEND);
		rdn(rr, 8'h00, 2); // end copies row
		op(OP_CSEQ);
		chk("err", 32'h1, {31'h0, rd[ST_ERR]}); // refused start
		$display("test cache done");
		bus(OFF_COL, 1'b1, 32'h0);
		bus(OFF_ROW, 1'b1, {24'h0, pg});
		op(OP_PROG);
		bus(OFF_DATA, 1'b1, $urandom);
		bus(OFF_COL, 1'b1, 32'h10);
		op(OP_RIN);
		bus(OFF_DATA, 1'b1, $urandom);
		op(OP_CONF);
		chk("stat", 32'hE080, rd & 32'hFF8D); // pass
		bus(OFF_DATA, 1'b1, 32'h0);
		bus(OFF_STAT, 1'b0, 32'h0);
		chk("err", 32'h1, {31'h0, rd[ST_ERR]}); // closed program
		op(OP_RMODE);
		chk("smode", 32'h0, {31'h0, rd[ST_SMODE]}); // data again
		repeat (3) op(OP_PROG);
		chk("err", 32'h0, {31'h0, rd[ST_ERR]}); // fourth partial
		op(OP_PROG);
		chk("err", 32'h1, {31'h0, rd[ST_ERR]}); // fifth refused
		bus(OFF_ROW, 1'b1, {24'h0, pg - 8'h01});
		op(OP_PROG);
		chk("err", 32'h1, {31'h0, rd[ST_ERR]}); // lower page
		bus(OFF_ROW, 1'b1, 32'h3F);
		op(OP_READ);
		op(OP_CSEQ);
		chk("err", 32'h1, {31'h0, rd[ST_ERR]}); // last page
		$display("test program done");
		give_verdict();
	end
endmodule : tb_top
